/* File: hw/osr_output_slew_ramp_softstart_ctrl.sv */
// Output slew limit, setpoint ramp, soft start and auto/manual selection.
// Assumes calculator and settings inputs are on ref_clk; only the
// auto/manual digital input pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none

module osr_output_slew_ramp_softstart_ctrl
  import osr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Calculator values
  input  wire logic [15:0] calcOutput,
  input  wire logic [15:0] measured_value,
  input  wire logic [15:0] target_setpoint,
  // Control status
  input  wire logic        runEnable,
  input  wire logic        onOffControl,
  input  wire logic        autoTuneActive,
  input  wire logic        autoTuneDone,
  input  wire logic        input_open,
  input  wire logic        input_over_range,
  input  wire logic        input_under_range,
  // Settings
  input  wire logic [9:0]  slewLimit,
  input  wire logic [13:0] rampUpRate,
  input  wire logic [13:0] rampDownRate,
  input  wire logic [1:0]  rampUnit,
  input  wire logic [13:0] softTime,
  input  wire logic [1:0]  softUnit,
  input  wire logic [15:0] softOutput,
  input  wire logic [15:0] stopOutput,
  input  wire logic [15:0] breakOutput,
  input  wire logic [15:0] stored_manual_start,
  input  wire logic        manualStartSel,
  // Writes
  input  wire logic        modeWrite,
  input  wire logic        modeWriteData,
  input  wire logic        heatWrite,
  input  wire logic [9:0]  heat_output_value,
  input  wire logic        coolWrite,
  input  wire logic [9:0]  cool_output_value,
  input  wire logic        paramWrite,
  // Digital input
  input  wire logic        dinAssigned,
  input  wire logic        dinManualPin,
  // Retained state from the settings store
  input  wire logic        restoreMode,
  input  wire logic [15:0] restoreManualOutput,
  // Results
  output logic [15:0]      manipulated_output_pct,
  output logic [15:0]      working_setpoint,
  output logic [15:0]      alarmSetpoint,
  output logic             rampActive,
  output logic             softStartActive,
  output logic             manualMode,
  output logic [15:0]      heldManualOutput,
  output logic             abortAutoTune,
  output logic             writeReject
);

  logic        tick;
  logic        dinSync1_q;
  logic        dinSync2_q;
  logic        startup_q;
  logic        manual_q;
  logic [15:0] manualOut_q;
  logic        modeReq;
  logic        inputFault;
  logic        firstTick_q;
  logic        atDoneSeen_q;
  logic [15:0] prevTarget_q;
  logic        prevRun_q;
  logic        prevManual_q;
  logic [13:0] prevUp_q;
  logic [13:0] prevDown_q;
  logic [1:0]  prevUnit_q;
  logic        startEvt;
  logic        stopEvt;
  logic [16:0] wspFrac_q;
  logic [16:0] slewFrac_q;
  logic [29:0] softElapsed_q;
  logic        softDone_q;
  logic [29:0] softLimit;
  logic        softRunNow;
  logic signed [16:0] rampBase;
  logic signed [16:0] rampTarget;
  logic signed [16:0] rampNext;
  logic        rampUp;
  logic [13:0] rampRate;
  logic [15:0] rampStep;
  logic [16:0] rampFracOut;
  logic signed [16:0] outNow;
  logic signed [16:0] outCalc;
  logic signed [16:0] slewNext;
  logic [15:0] slewStep;
  logic [16:0] slewFracOut;
  logic        slewOn;

  // ---------------------------------------------------------------
  // Tick and step helpers
  // ---------------------------------------------------------------
  osr_tick_gen #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick)
  );

  osr_rate_step #(
    .DIV (RAMP_DIV)
  ) u_ramp_step (
    .fracIn  (rampActive ? wspFrac_q : FRAC_RESET),
    .rate    (rampRate),
    .mult    (rampMult(rampUnit)),
    .step    (rampStep),
    .fracOut (rampFracOut)
  );

  osr_rate_step #(
    .DIV (SLEW_DIV)
  ) u_slew_step (
    .fracIn  (slewFrac_q),
    .rate    ({4'h0, slewLimit}),
    .mult    (SLEW_MULT),
    .step    (slewStep),
    .fracOut (slewFracOut)
  );

  // ---------------------------------------------------------------
  // Auto/manual mode
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dinSync1_q <= 1'b0;
      dinSync2_q <= 1'b0;
    end else begin
      dinSync1_q <= dinManualPin;
      dinSync2_q <= dinSync1_q;
    end
  end

  always_comb begin
    if (dinAssigned) begin
      modeReq = dinSync2_q;
    end else if (modeWrite) begin
      modeReq = modeWriteData;
    end else begin
      modeReq = manual_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startup_q   <= 1'b1;
      manual_q    <= MODE_AUTO;
      manualOut_q <= OUTPUT_RESET;
    end else if (startup_q) begin
      startup_q   <= 1'b0;
      manual_q    <= restoreMode;
      manualOut_q <= restoreManualOutput;
    end else begin
      manual_q <= modeReq;
      if (manual_q == MODE_AUTO && modeReq == MODE_MANUAL) begin
        if (manualStartSel == START_STORED) begin
          manualOut_q <= stored_manual_start;
        end else begin
          manualOut_q <= manipulated_output_pct;
        end
      end else if (manual_q && heatWrite) begin
        manualOut_q <= {6'h00, heat_output_value};
      end else if (manual_q && coolWrite) begin
        manualOut_q <= 16'h0000 - {6'h00, cool_output_value};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abortAutoTune <= 1'b0;
      writeReject   <= 1'b0;
    end else begin
      abortAutoTune <= !startup_q && !manual_q && modeReq
                       && autoTuneActive;
      writeReject   <= (paramWrite && manual_q)
                       || (modeWrite && dinAssigned);
    end
  end

  assign manualMode       = manual_q;
  assign heldManualOutput = manualOut_q;

  // ---------------------------------------------------------------
  // Ramp events
  // ---------------------------------------------------------------
  assign inputFault = input_open | input_over_range | input_under_range;

  always_comb begin
    startEvt = firstTick_q
               || (target_setpoint != prevTarget_q)
               || (runEnable && !prevRun_q)
               || (!manual_q && prevManual_q)
               || (rampUpRate != prevUp_q)
               || (rampDownRate != prevDown_q)
               || (rampUnit != prevUnit_q);
    stopEvt  = inputFault || autoTuneActive || atDoneSeen_q
               || (manual_q && !prevManual_q)
               || (!runEnable && prevRun_q)
               || (measured_value == target_setpoint);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      firstTick_q  <= 1'b1;
      atDoneSeen_q <= 1'b0;
      prevTarget_q <= OUTPUT_RESET;
      prevRun_q    <= 1'b0;
      prevManual_q <= MODE_AUTO;
      prevUp_q     <= RAMP_RATE_OFF;
      prevDown_q   <= RAMP_RATE_OFF;
      prevUnit_q   <= RAMP_UNIT_MIN;
    end else begin
      if (autoTuneDone) begin
        atDoneSeen_q <= 1'b1;
      end else if (tick) begin
        atDoneSeen_q <= 1'b0;
      end
      if (tick) begin
        firstTick_q  <= 1'b0;
        prevTarget_q <= target_setpoint;
        prevRun_q    <= runEnable;
        prevManual_q <= manual_q;
        prevUp_q     <= rampUpRate;
        prevDown_q   <= rampDownRate;
        prevUnit_q   <= rampUnit;
      end
    end
  end

  // ---------------------------------------------------------------
  // Setpoint ramp
  // ---------------------------------------------------------------
  always_comb begin
    if (rampActive) begin
      rampBase = 17'($signed(working_setpoint));
    end else begin
      rampBase = 17'($signed(measured_value));
    end
    rampTarget = 17'($signed(target_setpoint));
    rampUp     = rampTarget > rampBase;
    rampRate   = rampUp ? rampUpRate : rampDownRate;
    if (rampUp) begin
      rampNext = rampBase + $signed({1'b0, rampStep});
    end else begin
      rampNext = rampBase - $signed({1'b0, rampStep});
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rampActive       <= 1'b0;
      working_setpoint <= OUTPUT_RESET;
      wspFrac_q        <= FRAC_RESET;
      alarmSetpoint    <= OUTPUT_RESET;
    end else begin
      alarmSetpoint <= target_setpoint;
      if (tick) begin
        if (!stopEvt && (startEvt || rampActive)
            && rampRate != RAMP_RATE_OFF
            && rampBase != rampTarget
            && (rampUp ? rampNext < rampTarget
                       : rampNext > rampTarget)) begin
          rampActive       <= 1'b1;
          working_setpoint <= rampNext[15:0];
          wspFrac_q        <= rampFracOut;
        end else begin
          rampActive       <= 1'b0;
          working_setpoint <= target_setpoint;
          wspFrac_q        <= FRAC_RESET;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Soft start
  // ---------------------------------------------------------------
  always_comb begin
    softLimit  = 30'(softTime) * 30'(softTicks(softUnit));
    softRunNow = !softDone_q && !manual_q && runEnable && !inputFault
                 && softTime != SOFT_TIME_OFF
                 && softElapsed_q < softLimit;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      softDone_q      <= 1'b0;
      softStartActive <= 1'b0;
      softElapsed_q   <= '0;
    end else if (tick) begin
      if (softRunNow) begin
        softStartActive <= 1'b1;
        softElapsed_q   <= softElapsed_q + 30'h00000001;
      end else begin
        softStartActive <= 1'b0;
        softDone_q      <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output selection and slew limit
  // ---------------------------------------------------------------
  always_comb begin
    slewOn  = slewLimit >= SLEW_MIN && slewLimit <= SLEW_MAX;
    outNow  = 17'($signed(manipulated_output_pct));
    outCalc = 17'($signed(calcOutput));
    if (outCalc > outNow) begin
      slewNext = outNow + $signed({1'b0, slewStep});
    end else begin
      slewNext = outNow - $signed({1'b0, slewStep});
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      manipulated_output_pct <= OUTPUT_RESET;
      slewFrac_q             <= FRAC_RESET;
    end else if (startup_q) begin
      manipulated_output_pct <= restoreMode ? restoreManualOutput
                                            : OUTPUT_RESET;
    end else if (tick) begin
      slewFrac_q <= FRAC_RESET;
      if (manual_q) begin
        manipulated_output_pct <= manualOut_q;
      end else if (!runEnable) begin
        manipulated_output_pct <= stopOutput;
      end else if (inputFault) begin
        manipulated_output_pct <= breakOutput;
      end else if (softRunNow) begin
        manipulated_output_pct <= softOutput;
      end else if (autoTuneActive || onOffControl || !slewOn) begin
        manipulated_output_pct <= calcOutput;
      end else if (outCalc > outNow ? slewNext < outCalc
                                    : slewNext > outCalc) begin
        manipulated_output_pct <= slewNext[15:0];
        slewFrac_q             <= slewFracOut;
      end else begin
        manipulated_output_pct <= calcOutput;
      end
    end
  end

endmodule

`default_nettype wire

/* File: shared/osr_pkg.sv */
// Constants, unit decoders and reset values for the output slew, setpoint
// ramp and soft start controller.
// Assumes a single 20 MHz clock and a 50 ms sampling period.
//
// How it works
// - Output change per second is clamped only when the computed change exceeds the limit.
// - Slew limit in 0.1 %/s, 1 to 999 valid; 0 or 1000 mean off.
// - Slew limit bypassed in manual, auto-tune, on/off, stop and break output.
// - Slew step applied once per 50 ms tick, rate scaled to the tick.
// - Separate up and down ramp rates 0 to 9999; zero disables that direction.
// - Ramp unit encodes seconds, minutes, hours; minutes by default.
// - Working setpoint advances each tick by rate scaled from its time unit.
// - Ramp from idle starts at measured value; mid-ramp changes continue from it.
// - Ramp stops on input fault, auto-tune, switch to manual, run stop, or value reached.
// - Nonzero rate starts a ramp at power-up, setpoint, run, auto or rate change.
// - Alarms use the final target setpoint while ramping.
// - Soft start runs once after power-up; skipped in manual, stop or input fault.
// - Soft start time 0 is off, 1 to 9999; unit seconds, minutes or hours.
// - Soft start parameter changes apply with elapsed time still counted.
// - Mode selector auto or manual, auto by default, kept across power cycles.
// - With the digital input assigned, mode follows it and mode writes are refused.
// - Switching to manual aborts a running auto-tune.
// - Manual allowed in stop and break; output priority manual, stop, break.
// - In manual only heat, cool and mode writes are accepted.
// - Manual start value is last auto output or stored preset, auto by default.
// - Auto/manual switching allowed for on/off as well as PID control.
// - Output is signed: positive drives heating, negative drives cooling.
// - After power returns in manual, the previous manual output resumes.

package osr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int SAMPLE_MS      = 50;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int TICKS_PER_SEC  = 1000 / SAMPLE_MS;
  localparam int TICKS_PER_MIN  = TICKS_PER_SEC * 60;
  localparam int TICKS_PER_HOUR = TICKS_PER_MIN * 60;

  // ---------------------------------------------------------------
  // Slew limit
  // ---------------------------------------------------------------
  localparam logic [9:0]  SLEW_MIN   = 10'h001;
  localparam logic [9:0]  SLEW_MAX   = 10'h3e7;
  localparam int          SLEW_DIV   = TICKS_PER_SEC;
  localparam logic [11:0] SLEW_MULT  = 12'h001;

  // ---------------------------------------------------------------
  // Setpoint ramp
  // ---------------------------------------------------------------
  localparam logic [13:0] RAMP_RATE_OFF  = 14'h0000;
  localparam logic [1:0]  RAMP_UNIT_SEC  = 2'h1;
  localparam logic [1:0]  RAMP_UNIT_MIN  = 2'h2;
  localparam logic [1:0]  RAMP_UNIT_HOUR = 2'h3;
  localparam int          RAMP_DIV       = TICKS_PER_HOUR;
  localparam logic [11:0] RAMP_MULT_SEC  = 12'(RAMP_DIV / TICKS_PER_SEC);
  localparam logic [11:0] RAMP_MULT_MIN  = 12'(RAMP_DIV / TICKS_PER_MIN);
  localparam logic [11:0] RAMP_MULT_HOUR = 12'(RAMP_DIV / TICKS_PER_HOUR);

  // ---------------------------------------------------------------
  // Soft start
  // ---------------------------------------------------------------
  localparam logic [13:0] SOFT_TIME_OFF  = 14'h0000;
  localparam logic [1:0]  SOFT_UNIT_SEC  = 2'h0;
  localparam logic [1:0]  SOFT_UNIT_MIN  = 2'h1;
  localparam logic [1:0]  SOFT_UNIT_HOUR = 2'h2;

  // ---------------------------------------------------------------
  // Mode and reset values
  // ---------------------------------------------------------------
  localparam logic        MODE_AUTO    = 1'b0;
  localparam logic        MODE_MANUAL  = 1'b1;
  localparam logic        START_CARRY  = 1'b0;
  localparam logic        START_STORED = 1'b1;
  localparam logic [15:0] OUTPUT_RESET = 16'h0000;
  localparam logic [16:0] FRAC_RESET   = 17'h00000;

  // Ramp rate multiplier towards a per-hour-tick fraction
  function automatic logic [11:0] rampMult(input logic [1:0] unit);
    case (unit)
      RAMP_UNIT_SEC:  rampMult = RAMP_MULT_SEC;
      RAMP_UNIT_HOUR: rampMult = RAMP_MULT_HOUR;
      default:        rampMult = RAMP_MULT_MIN;
    endcase
  endfunction

  // Ticks in one soft start time unit
  function automatic logic [16:0] softTicks(input logic [1:0] unit);
    case (unit)
      SOFT_UNIT_MIN:  softTicks = 17'(TICKS_PER_MIN);
      SOFT_UNIT_HOUR: softTicks = 17'(TICKS_PER_HOUR);
      default:        softTicks = 17'(TICKS_PER_SEC);
    endcase
  endfunction

endpackage

/* File: hw/osr_tick_gen.sv */
// Sampling tick generator.
// Assumes ref_clk is the only clock; emits a one-cycle tick per period.
`timescale 1ns/1ns
`default_nettype none

module osr_tick_gen #(
  parameter int unsigned CYCLES = 1000000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Tick
  output logic      tick
);

  localparam int W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count_q;

  // ---------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= (count_q == LAST);
      if (count_q == LAST) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + W'(1);
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/osr_rate_step.sv */
// Per-tick step of a rate with fractional carry.
// Assumes rate times mult plus fraction stays below 2^32.
`timescale 1ns/1ns
`default_nettype none

module osr_rate_step #(
  parameter int DIV = 20
) (
  // Operands
  input  wire logic [16:0] fracIn,
  input  wire logic [13:0] rate,
  input  wire logic [11:0] mult,
  // Result
  output logic      [15:0] step,
  output logic      [16:0] fracOut
);

  localparam logic [31:0] DIV_W = 32'(DIV);

  logic [31:0] sum;
  logic [31:0] quot;
  logic [31:0] rem;

  // ---------------------------------------------------------------
  // Whole step and carried remainder
  // ---------------------------------------------------------------
  always_comb begin
    sum     = 32'(fracIn) + 32'(rate) * 32'(mult);
    quot    = sum / DIV_W;
    rem     = sum % DIV_W;
    step    = quot[15:0];
    fracOut = rem[16:0];
  end

endmodule

`default_nettype wire

/* File: sim/osr_ctrl_monitor.sv */
// Assertion checker for the slew, ramp and soft start controller.
// Assumes one clock domain; bound to the top module by name.
`timescale 1ns/1ns
`default_nettype none

module osr_ctrl_monitor #(
  parameter int unsigned TICK_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Watched inputs
  input wire logic [15:0] target_setpoint,
  input wire logic        autoTuneActive,
  input wire logic        modeWrite,
  input wire logic        heatWrite,
  input wire logic        coolWrite,
  input wire logic        paramWrite,
  input wire logic        dinAssigned,
  input wire logic        manualStartSel,
  // Watched outputs
  input wire logic [15:0] manipulated_output_pct,
  input wire logic [15:0] working_setpoint,
  input wire logic [15:0] alarmSetpoint,
  input wire logic [15:0] heldManualOutput,
  input wire logic        rampActive,
  input wire logic        softStartActive,
  input wire logic        manualMode,
  input wire logic        abortAutoTune,
  input wire logic        writeReject
);
  int unsigned tickPhase;
  int unsigned manualRun;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      tickPhase <= 0;
    else
      tickPhase <= (tickPhase == TICK_CYCLES_P - 1) ? 0 : tickPhase + 1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      manualRun <= 0;
    else if (!manualMode || heatWrite || coolWrite)
      manualRun <= 0;
    else if (manualRun <= TICK_CYCLES_P + 2)
      manualRun <= manualRun + 1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_alarmLag;
    !$past(rst) |-> alarmSetpoint == $past(target_setpoint);
  endproperty
  a_alarmLag: assert property (p_alarmLag) else $error("alarm lag");
  property p_abortTune;
    $rose(manualMode) && $past(modeWrite) && $past(autoTuneActive)
      |-> abortAutoTune;
  endproperty
  a_abortTune: assert property (p_abortTune) else $error("no abort");
  property p_rejectParam;
    paramWrite && manualMode |=> writeReject;
  endproperty
  a_rejectParam: assert property (p_rejectParam) else $error("accepted");
  property p_rejectMode;
    modeWrite && dinAssigned |=> writeReject ##1 !writeReject;
  endproperty
  a_rejectMode: assert property (p_rejectMode) else $error("mode taken");
  property p_noReject;
    !(paramWrite && manualMode) && !(modeWrite && dinAssigned) |=> !writeReject;
  endproperty
  a_noReject: assert property (p_noReject) else $error("bad reject");
  property p_tickOnly;
    $changed({manipulated_output_pct, working_setpoint, rampActive,
              softStartActive}) |-> tickPhase == 1;
  endproperty
  a_tickOnly: assert property (p_tickOnly) else $error("off tick");
  property p_carryStart;
    $rose(manualMode) && $past(modeWrite) && !$past(manualStartSel)
      |-> heldManualOutput == $past(manipulated_output_pct);
  endproperty
  a_carryStart: assert property (p_carryStart) else $error("start");
  property p_manualDrive;
    manualRun >= TICK_CYCLES_P + 2 |-> manipulated_output_pct == heldManualOutput;
  endproperty
  a_manualDrive: assert property (p_manualDrive) else $error("manual");
endmodule

bind osr_output_slew_ramp_softstart_ctrl osr_ctrl_monitor #(
  .TICK_CYCLES_P(TICK_CYCLES_P)
) mon (.*);
`default_nettype wire

/* File: sim/osr_store_model.sv */
// Partner model: settings store keeping mode and manual output.
// Assumes it saves on each ref_clk edge outside reset.
`timescale 1ns/1ns
`default_nettype none

module osr_store_model
  import osr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Saved values
  input  wire logic        manualMode,
  input  wire logic [15:0] heldManualOutput,
  // Values offered at power-up
  output var logic         restoreMode,
  output var logic  [15:0] restoreManualOutput
);
  initial begin
    restoreMode = MODE_AUTO;
    restoreManualOutput = OUTPUT_RESET;
  end
  always @(posedge ref_clk) begin
    if (!rst) begin
      restoreMode <= manualMode;
      restoreManualOutput <= heldManualOutput;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench for the slew, ramp and soft start controller.
// Assumes the checker binds itself and ref_clk runs at 20 MHz.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import osr_pkg::*;
  localparam int T = 20;
  logic        ref_clk, rst, runEnable, onOffControl, autoTuneActive;
  logic        autoTuneDone, input_open, input_over_range, manualStartSel;
  logic        input_under_range, modeWrite, modeWriteData, heatWrite;
  logic        coolWrite, paramWrite, dinAssigned, dinManualPin;
  logic        restoreMode, rampActive, softStartActive, manualMode;
  logic        abortAutoTune, writeReject;
  logic [15:0] calcOutput, measured_value, target_setpoint, softOutput;
  logic [15:0] stopOutput, breakOutput, stored_manual_start, alarmSetpoint;
  logic [15:0] restoreManualOutput, manipulated_output_pct, heldManualOutput;
  logic [15:0] working_setpoint;
  logic [9:0]  slewLimit, heat_output_value, cool_output_value;
  logic [13:0] rampUpRate, rampDownRate, softTime;
  logic [1:0]  rampUnit, softUnit;
  logic signed [15:0] w0, w1;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc;

  osr_output_slew_ramp_softstart_ctrl #(.TICK_CYCLES_P(T)) dut (.*);
  osr_store_model store (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk or posedge rst) cyc <= rst ? 0 : cyc + 1;

  task summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task chkB(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t flag wrong", $time);
    end
  endtask
  // Waits n ticks
  task tk(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      repeat ((T + 2 - cyc % T) % T) @(negedge ref_clk);
    end
  endtask
  task doReset;
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    tk(1);
  endtask
  task wr(input logic [3:0] w, input logic d);
    @(negedge ref_clk);
    {modeWrite, heatWrite, coolWrite, paramWrite} = w;
    modeWriteData = d;
    @(negedge ref_clk);
    {modeWrite, heatWrite, coolWrite, paramWrite} = 4'h0;
  endtask

  task t_soft;
    tk(1);
    chkB(softStartActive);
    chk(manipulated_output_pct, 16'h012c);
    tk(9);
    softTime = 14'h0001;
    softOutput = 16'h00c8;
    tk(1);
    chk(manipulated_output_pct, 16'h00c8);
    tk(12);
    chkB(!softStartActive);
    softTime = 14'h0002;
    tk(1);
    chkB(!softStartActive);
    chk(manipulated_output_pct, 16'h01f4);
  endtask
  task t_slew;
    slewLimit = 10'h06e;
    calcOutput = 16'hfe0c;
    tk(2);
    chk(manipulated_output_pct, 16'h01e9);
    calcOutput = 16'h01e7;
    tk(1);
    chk(manipulated_output_pct, 16'h01e7);
    slewLimit = 10'h3e8;
    calcOutput = 16'hfe0c;
    tk(1);
    chk(manipulated_output_pct, 16'hfe0c);
    slewLimit = 10'h06e;
    onOffControl = 1'b1;
    calcOutput = 16'h01f4;
    tk(1);
    chk(manipulated_output_pct, 16'h01f4);
    onOffControl = 1'b0;
    runEnable = 1'b0;
    tk(1);
    chk(manipulated_output_pct, 16'hffb3);
    {runEnable, input_open} = 2'h3;
    tk(1);
    chk(manipulated_output_pct, 16'h0000);
    input_open = 1'b0;
    slewLimit = 10'h000;
  endtask
  task t_ramp;
    int e;
    int d;
    rampUpRate = 14'h02d0;
    target_setpoint = 16'h2710;
    w1 = '0;
    for (int u = 1; u < 4; u++) begin
      rampUnit = 2'(u);
      e = (u == 1) ? 360 : (u == 2) ? 6 : 0;
      tk(2);
      w0 = working_setpoint;
      chkB(rampActive && w0 >= w1 && w0 <= w1 + 16'sd80);
      tk(10);
      w1 = working_setpoint;
      d = int'(w1 - w0);
      chkB(d >= e - 1 && d <= e + 1);
    end
    target_setpoint = 16'hff9c;
    tk(2);
    chk(working_setpoint, 16'hff9c);
    rampUnit = 2'h1;
    target_setpoint = 16'h012c;
    tk(2);
    chkB(rampActive);
    measured_value = 16'h012c;
    tk(2);
    chkB(!rampActive && working_setpoint === 16'h012c);
    rampUpRate = 14'h0000;
  endtask
  task t_manual;
    calcOutput = 16'h00c8;
    autoTuneActive = 1'b1;
    tk(1);
    wr(4'h8, 1'b1);
    chkB(manualMode && abortAutoTune);
    chk(heldManualOutput, 16'h00c8);
    autoTuneActive = 1'b0;
    wr(4'h4, 1'b0);
    tk(1);
    chk(manipulated_output_pct, 16'h00fa);
    wr(4'h2, 1'b0);
    tk(1);
    chk(manipulated_output_pct, 16'hff9c);
    wr(4'h1, 1'b0);
    chkB(writeReject);
    runEnable = 1'b0;
    input_open = 1'b1;
    tk(1);
    chk(manipulated_output_pct, 16'hff9c);
    runEnable = 1'b1;
    input_open = 1'b0;
    doReset;
    chkB(manualMode);
    chk(manipulated_output_pct, 16'hff9c);
  endtask
  task t_select;
    wr(4'h8, 1'b0);
    onOffControl = 1'b1;
    manualStartSel = 1'b1;
    wr(4'h8, 1'b1);
    chkB(manualMode);
    chk(heldManualOutput, 16'h007b);
    wr(4'h8, 1'b0);
    dinAssigned = 1'b1;
    wr(4'h8, 1'b1);
    chkB(writeReject && !manualMode);
    dinManualPin = 1'b1;
    for (int i = 0; i < 10 && manualMode !== 1'b1; i++) @(negedge ref_clk);
    chkB(manualMode);
  endtask

  initial begin
    rst = 1'b1;
    {onOffControl, autoTuneActive, autoTuneDone, input_open} = '0;
    {input_over_range, input_under_range, manualStartSel, dinAssigned} = '0;
    {modeWrite, modeWriteData, heatWrite, coolWrite, paramWrite} = '0;
    dinManualPin = 1'b0;
    runEnable = 1'b1;
    {calcOutput, measured_value, target_setpoint} = {16'h01f4, 32'h0};
    {slewLimit, rampUpRate, rampDownRate} = '0;
    {rampUnit, softUnit, softTime} = {2'h2, 2'h0, 14'h0002};
    {softOutput, stopOutput, breakOutput} = {16'h012c, 16'hffb3, 16'h0};
    stored_manual_start = 16'h007b;
    {heat_output_value, cool_output_value} = {10'h0fa, 10'h064};
    doReset;
    chkB(!manualMode);
    t_soft;
    t_slew;
    t_ramp;
    t_manual;
    t_select;
    summarize;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    summarize;
  end
endmodule
`default_nettype wire
